// ### verilog/program_sequencer.sv
// Purpose: program counter, return stack, vectors, alu and table reads
// Assumes: one instruction cycle per core_clk when instr_valid and instr_ready are high
// Notes:   instructions arrive already decoded from program memory
`timescale 1ns/100ps
`include "seq_cfg.svh"

// Function
// - pc increments after ordinary instructions
// - only pc low byte is software visible
// - jumps, calls, interrupts, reset load target
// - taken skip inserts a dummy cycle
// - pc width follows memory size
// - low byte write jumps within page
// - low byte write inserts dummy cycle
// - eight level hidden return stack
// - call/interrupt push, returns pop
// - reset empties the stack
// - full stack holds off interrupt acknowledge
// - call on full stack still executes
// - alu writes result and updates flags
// - alu supports full arithmetic/logic set
// - program memory is 16-bit words
// - bank select bits 5 and 6 choose bank
// - execution starts at reset vector
// - external edge vector, selectable edge
// - each timer overflow has own vector
// - time base and serial share vector
// - table pointer gives low address byte
// - current page or last page table read
// - low byte to register, high to latch
// - table reads take two cycles
// - current page top bits from bank select
// - jumps and calls take two cycles
module program_sequencer
    import seq_pkg::*;
#(
    parameter int PC_WIDTH = 15
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // avalon-mm slave
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // decoded instruction
    input  wire logic                 instr_valid,
    input  wire instr_type            instr,
    output logic                      instr_ready,
    // program memory
    output logic      [PC_WIDTH-1:0]  prog_addr,
    input  wire logic [15:0]          prog_data,
    // alu and table results
    output logic                      result_valid,
    output alu_out_type               result,
    output logic                      tbl_low_valid,
    output logic      [7:0]           tbl_low_data,
    // interrupt sources
    input  wire logic                 ext_int_pin,
    input  wire logic                 tmr0_ovf,
    input  wire logic                 tmr1_ovf,
    input  wire logic                 tmr2_ovf,
    input  wire logic                 tbase_ovf,
    input  wire logic                 serial_done,
    output logic                      int_ack
);
    localparam int SP_W = $clog2(`STACK_DEPTH + 1);

    // registers
    logic [PC_WIDTH-1:0] pc_reg, pc_next;
    logic [PC_WIDTH-1:0] stack_reg [`STACK_DEPTH];
    logic [SP_W-1:0]     stack_level_index_reg;
    logic [7:0]          table_low_pointer_reg;
    logic [7:0]          table_high_latch_reg;
    logic [7:0]          bank_select_register_reg;
    logic [7:0]          control_reg_one_reg; // [1:0] edge, [7:2] enables
    logic [5:0]          int_flag_reg;
    logic                carry_reg;
    logic [2:0]          pin_sync_reg;
    seq_state_type       state_reg, state_next;
    logic                pcl_wr_pending_reg;
    logic [7:0]          pcl_wr_data_reg;
    logic                tbl_last_reg;

    // input pin passes two flops before edge detection
    logic ext_rise, ext_fall, ext_edge;
    assign ext_rise = pin_sync_reg[1] & ~pin_sync_reg[2];
    assign ext_fall = ~pin_sync_reg[1] & pin_sync_reg[2];
    assign ext_edge = (control_reg_one_reg[0] & ext_fall) |
                      (control_reg_one_reg[1] & ext_rise);

    // interrupt events and arbitration
    logic [5:0] int_event, int_pending;
    logic       stack_full, stack_empty, take_int;
    logic [2:0] int_sel;
    logic [PC_WIDTH-1:0] int_vec;
    assign int_event = {serial_done, tbase_ovf, tmr2_ovf, tmr1_ovf,
                        tmr0_ovf, ext_edge};
    assign int_pending = int_flag_reg & control_reg_one_reg[7:2];
    assign stack_full  = (stack_level_index_reg == SP_W'(`STACK_DEPTH));
    assign stack_empty = (stack_level_index_reg == '0);
    // flag is still recorded; only the acknowledge waits for room
    assign take_int = (state_reg == st_fetch) && (|int_pending) &&
                      !stack_full && !pcl_wr_pending_reg;
    always_comb begin
        int_sel = 3'd0;
        for (int i = 5; i >= 0; i--) begin
            if (int_pending[i]) begin
                int_sel = 3'(i);
            end
        end
    end
    always_comb begin
        unique case (int_sel)
            3'd0:    int_vec = PC_WIDTH'(`EXT_INT_VEC);
            3'd1:    int_vec = PC_WIDTH'(`TMR0_VEC);
            3'd2:    int_vec = PC_WIDTH'(`TMR1_VEC);
            3'd3:    int_vec = PC_WIDTH'(`TMR2_VEC);
            default: int_vec = PC_WIDTH'(`MULTI_VEC);
        endcase
    end

    // bank bits and table address
    logic [PC_WIDTH-1:0] bank_top, tbl_addr, pc_inc;
    logic [7:0]          tbl_high;
    always_comb begin
        bank_top = '0;
        bank_top[PC_WIDTH-1] = bank_select_register_reg[`BANK_HI_BIT];
        if (PC_WIDTH > 14) begin
            bank_top[PC_WIDTH-2] = bank_select_register_reg[`BANK_LO_BIT];
        end
        if (PC_WIDTH == 14) begin
            bank_top[PC_WIDTH-1] = bank_select_register_reg[`BANK_LO_BIT];
        end
    end
    localparam int MIDW = PC_WIDTH - `PAGE_BITS - ((PC_WIDTH > 14) ? 2 : 1);
    assign tbl_addr = tbl_last_reg ?
        {{(PC_WIDTH-`PAGE_BITS){1'b1}}, table_low_pointer_reg} :
        (bank_top | {{(PC_WIDTH-MIDW-`PAGE_BITS){1'b0}},
                     pc_reg[`PAGE_BITS+MIDW-1:`PAGE_BITS],
                     table_low_pointer_reg});
    assign tbl_high = prog_data[15:8];
    assign pc_inc   = pc_reg + PC_WIDTH'(`ONE_PC);

    // alu, eight bit with carry and decimal adjust
    alu_out_type alu;
    logic [8:0]  wide;
    always_comb begin
        wide = 9'h000;
        unique case (instr.fn)
            alu_add:  wide = {1'b0, instr.a} + {1'b0, instr.b};
            alu_adc:  wide = {1'b0, instr.a} + {1'b0, instr.b} +
                             {8'h00, carry_reg};
            alu_sub:  wide = {1'b0, instr.a} + {1'b0, ~instr.b} + 9'h001;
            alu_sbc:  wide = {1'b0, instr.a} + {1'b0, ~instr.b} +
                             {8'h00, carry_reg};
            alu_and:  wide = {carry_reg, instr.a & instr.b};
            alu_or:   wide = {carry_reg, instr.a | instr.b};
            alu_xor:  wide = {carry_reg, instr.a ^ instr.b};
            alu_cpl:  wide = {carry_reg, ~instr.a};
            alu_rl:   wide = {carry_reg, instr.a[6:0], instr.a[7]};
            alu_rlc:  wide = {instr.a, carry_reg};
            alu_rr:   wide = {carry_reg, instr.a[0], instr.a[7:1]};
            alu_rrc:  wide = {instr.a[0], carry_reg, instr.a[7:1]};
            alu_inc:  wide = {carry_reg, instr.a + 8'h01};
            alu_dec:  wide = {carry_reg, instr.a - 8'h01};
            alu_daa:  begin
                wide = {1'b0, instr.a};
                if (wide[3:0] > 4'h9) begin
                    wide = wide + 9'h006;
                end
                if (wide[8] || carry_reg || wide[7:4] > 4'h9) begin
                    wide = wide + 9'h060;
                end
            end
            alu_pass: wide = {carry_reg, instr.a};
        endcase
        alu.data      = wide[7:0];
        alu.carry     = wide[8];
        alu.aux_carry = (instr.a[3:0] + instr.b[3:0]) > 5'h0f;
        alu.zero      = (wide[7:0] == 8'h00);
        alu.overflow  = (instr.a[7] == instr.b[7]) &&
                        (wide[7] != instr.a[7]);
    end

    // skip decision uses the alu result
    logic skip_taken;
    assign skip_taken = (instr.op == op_skip) &&
                        (alu.zero == instr.skip_if_zero);

    // bus decode; every access answers in the cycle it is seen, except a pc low write while a previous one is pending
    logic hit_pcl, hit_tbl, hit_bank, hit_ctrl, wr_pcl;
    assign hit_pcl  = (avs_address == `PC_LOW_OFS);
    assign hit_tbl  = (avs_address == `TBL_PTR_OFS);
    assign hit_bank = (avs_address == `BANK_SEL_OFS);
    assign hit_ctrl = (avs_address == `INT_CTRL_OFS);
    assign wr_pcl   = avs_write & hit_pcl & avs_byteenable[0];
    // a pc write waits while a previous one is still being taken
    assign avs_waitrequest = avs_write & hit_pcl & pcl_wr_pending_reg;
    always_comb begin
        unique case (avs_address)
            `PC_LOW_OFS:     avs_readdata = {24'h0, pc_reg[7:0]};
            `TBL_PTR_OFS:    avs_readdata = {24'h0, table_low_pointer_reg};
            `TBL_HIGH_OFS:   avs_readdata = {24'h0, table_high_latch_reg};
            `BANK_SEL_OFS:   avs_readdata = {24'h0, bank_select_register_reg};
            `STACK_STAT_OFS: avs_readdata = {30'h0, stack_full, stack_empty};
            `INT_CTRL_OFS:   avs_readdata = {18'h0, int_flag_reg,
                                             control_reg_one_reg};
            `PC_STAT_OFS:    avs_readdata = {16'h0, 1'b0, carry_reg,
                                             state_reg, 3'h0, 8'h0};
            default:         avs_readdata = 32'h0000_0000;
        endcase
    end

    // sequencing: next state and next pc
    always_comb begin
        state_next = state_reg;
        pc_next    = pc_reg;
        unique case (state_reg)
            st_fetch: begin
                if (take_int) begin
                    pc_next    = int_vec;
                    state_next = st_dummy;
                end else if (pcl_wr_pending_reg) begin
                    pc_next    = {pc_reg[PC_WIDTH-1:`PAGE_BITS],
                                  pcl_wr_data_reg};
                    state_next = st_dummy;
                end else if (instr_valid) begin
                    unique case (instr.op)
                        op_jump, op_call: begin
                            pc_next    = instr.target;
                            state_next = st_dummy;
                        end
                        op_ret, op_interrupt_return: begin
                            pc_next = stack_reg[3'(stack_level_index_reg
                                                   - SP_W'(1))];
                            state_next = st_dummy;
                        end
                        op_skip: begin
                            pc_next    = skip_taken ? pc_inc + 
                                         PC_WIDTH'(`ONE_PC) : pc_inc;
                            state_next = skip_taken ? st_dummy : st_fetch;
                        end
                        op_tbl_cur, op_tbl_last: begin
                            state_next = st_exec;
                        end
                        default: pc_next = pc_inc;
                    endcase
                end
            end
            st_exec: begin
                pc_next    = pc_inc;
                state_next = st_fetch;
            end
            st_dummy: state_next = st_fetch;
        endcase
    end
    // nothing is taken while a vector or a pc low write is being applied
    assign instr_ready = (state_reg == st_fetch) && !take_int &&
                         !pcl_wr_pending_reg;
    assign prog_addr   = (state_reg == st_exec) ? tbl_addr : pc_reg;

    // pc, state, pin sampling
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_reg       <= PC_WIDTH'(`RESET_VEC);
            state_reg    <= st_fetch;
            pin_sync_reg <= 3'h0;
        end else begin
            pc_reg       <= pc_next;
            state_reg    <= state_next;
            pin_sync_reg <= {pin_sync_reg[1:0], ext_int_pin};
        end
    end

    // return stack; no guard on a full push
    logic do_push, do_pop;
    logic [PC_WIDTH-1:0] push_val;
    assign do_push  = take_int || (instr_ready && instr_valid &&
                      instr.op == op_call);
    assign do_pop   = instr_ready && instr_valid && !stack_empty &&
                      (instr.op == op_ret || instr.op == op_interrupt_return);
    assign push_val = take_int ? pc_reg : pc_inc;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_level_index_reg <= '0;
        end else if (do_push) begin
            // a push on a full stack overwrites the newest entry
            stack_reg[3'(stack_level_index_reg - SP_W'(stack_full))]
                <= push_val;
            if (!stack_full) begin
                stack_level_index_reg <= stack_level_index_reg + SP_W'(1);
            end
        end else if (do_pop) begin
            stack_level_index_reg <= stack_level_index_reg - SP_W'(1);
        end
    end

    // software registers and pending pc low write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            table_low_pointer_reg    <= 8'h00;
            bank_select_register_reg <= 8'h00;
            control_reg_one_reg      <= 8'h00;
            pcl_wr_pending_reg       <= 1'b0;
            pcl_wr_data_reg          <= 8'h00;
        end else begin
            if (avs_write && avs_byteenable[0] && hit_tbl) begin
                table_low_pointer_reg <= avs_writedata[7:0];
            end
            if (avs_write && avs_byteenable[0] && hit_bank) begin
                bank_select_register_reg <= avs_writedata[7:0];
            end
            if (avs_write && avs_byteenable[0] && hit_ctrl) begin
                control_reg_one_reg <= avs_writedata[7:0];
            end
            if (wr_pcl && !pcl_wr_pending_reg) begin
                pcl_wr_pending_reg <= 1'b1;
                pcl_wr_data_reg    <= avs_writedata[7:0];
            end else if (state_reg == st_fetch && !take_int) begin
                pcl_wr_pending_reg <= 1'b0;
            end
        end
    end

    // interrupt flags: a new event beats the acknowledge clear
    logic [5:0] ack_clear;
    assign ack_clear = take_int ? (6'h01 << int_sel) : 6'h00;
    assign int_ack   = take_int;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_flag_reg <= 6'h00;
        end else begin
            int_flag_reg <= (int_flag_reg & ~ack_clear) | int_event;
        end
    end

    // alu results, status flags and table data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_valid         <= 1'b0;
            result               <= '0;
            carry_reg            <= 1'b0;
            tbl_low_valid        <= 1'b0;
            tbl_low_data         <= 8'h00;
            table_high_latch_reg <= 8'h00;
            tbl_last_reg         <= 1'b0;
        end else begin
            result_valid  <= 1'b0;
            tbl_low_valid <= 1'b0;
            if (instr_ready && instr_valid && instr.op == op_alu) begin
                result_valid <= 1'b1;
                result       <= alu;
                carry_reg    <= alu.carry;
            end
            if (instr_ready && instr_valid) begin
                tbl_last_reg <= (instr.op == op_tbl_last);
            end
            if (state_reg == st_exec) begin
                tbl_low_valid        <= 1'b1;
                tbl_low_data         <= prog_data[7:0];
                table_high_latch_reg <= tbl_high;
            end
        end
    end
endmodule : program_sequencer

// ### verilog/seq_cfg.svh
// Purpose: constants for the program sequencer
// Assumes: included by the sequencer, the properties and the testbench
// Notes:   register offsets are word addresses on the avalon bus
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define PC_LOW_OFS        4'h0
`define TBL_PTR_OFS       4'h1
`define TBL_HIGH_OFS      4'h2
`define BANK_SEL_OFS      4'h3
`define STACK_STAT_OFS    4'h4
`define INT_CTRL_OFS      4'h5
`define PC_STAT_OFS       4'h6
`define RESET_VEC         15'h0000
`define EXT_INT_VEC       15'h0004
`define TMR0_VEC          15'h0008
`define TMR1_VEC          15'h000c
`define TMR2_VEC          15'h0010
`define MULTI_VEC         15'h0014
`define BANK_LO_BIT       5
`define BANK_HI_BIT       6
`define STACK_DEPTH       8
`define PAGE_BITS         8
`define ONE_PC            15'h0001
`endif

// ### verilog/seq_pkg.sv
// Purpose: types shared by the program sequencer
// Assumes: seq_cfg.svh holds the numbers
// Notes:   none
package seq_pkg;
    typedef enum logic [4:0] {
        op_none   = 5'h00, op_jump   = 5'h01, op_call   = 5'h02,
        op_ret    = 5'h03, op_interrupt_return   = 5'h04, op_alu    = 5'h05,
        op_skip   = 5'h06, op_tbl_cur = 5'h07, op_tbl_last = 5'h08
    } op_type;

    typedef enum logic [3:0] {
        alu_add = 4'h0, alu_adc = 4'h1, alu_sub = 4'h2, alu_sbc = 4'h3,
        alu_and = 4'h4, alu_or  = 4'h5, alu_xor = 4'h6, alu_cpl = 4'h7,
        alu_rl  = 4'h8, alu_rlc = 4'h9, alu_rr  = 4'ha, alu_rrc = 4'hb,
        alu_inc = 4'hc, alu_dec = 4'hd, alu_daa = 4'he, alu_pass = 4'hf
    } alu_fn_type;

    // decoded instruction handed in by the decoder
    typedef struct packed {
        op_type     op;
        alu_fn_type fn;
        logic [7:0] a;
        logic [7:0] b;
        logic [14:0] target;
        logic       skip_if_zero;
    } instr_type;

    typedef struct packed {
        logic [7:0] data;
        logic       carry;
        logic       aux_carry;
        logic       zero;
        logic       overflow;
    } alu_out_type;

    typedef enum logic [2:0] {
        st_fetch = 3'b001,
        st_exec  = 3'b010,
        st_dummy = 3'b100
    } seq_state_type;
endpackage : seq_pkg

// ### verif/prog_mem_model.sv
// Purpose: program memory seen by the sequencer
// Assumes: combinational word read, same cycle as the address
// Notes:   word pattern mixes page and offset so wrong pages show
`timescale 1ns/100ps
module prog_mem_model (
    input  wire logic [14:0] prog_addr,
    output logic      [15:0] prog_data
);
    // sixteen-bit words, high byte from the offset, low byte from the page
    assign prog_data = {prog_addr[7:0] ^ 8'h3c, prog_addr[14:7]};
endmodule : prog_mem_model

// ### verif/seq_props.sv
// Purpose: port-level checks of the program sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   helper register keeps the last accepted target
`timescale 1ns/100ps
`include "seq_cfg.svh"
module seq_props
    import seq_pkg::*;
#(
    parameter int PC_WIDTH = 15
) (
    input wire logic                core_clk,
    input wire logic                reset_n,
    input wire logic [3:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic                instr_valid,
    input wire instr_type           instr,
    input wire logic                instr_ready,
    input wire logic [PC_WIDTH-1:0] prog_addr,
    input wire logic                result_valid,
    input wire logic                tbl_low_valid,
    input wire logic                int_ack
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // an instruction is taken on this edge
    wire take = instr_valid && instr_ready;
    wire tbl_op = instr.op == op_tbl_cur || instr.op == op_tbl_last;
    logic [PC_WIDTH-1:0] tgt_reg;
    // target kept for the check one or two cycles later
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) tgt_reg <= '0;
        else if (take) tgt_reg <= instr.target[PC_WIDTH-1:0];
    end
    wait_only_a: assert property (avs_waitrequest |->
        avs_write && avs_address == `PC_LOW_OFS) else $error("stray wait");
    unmapped_zero_a: assert property (avs_read && avs_address > 4'h6
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    jump_target_a: assert property (take && instr.op == op_jump
        |=> ##[0:1] prog_addr == tgt_reg) else $error("jump target lost");
    branch_dummy_a: assert property (take && (instr.op == op_jump ||
        instr.op == op_call || instr.op == op_ret) |=> !instr_ready)
        else $error("no dummy cycle after branch");
    alu_result_a: assert property (take && instr.op == op_alu
        |=> result_valid) else $error("alu result missing");
    table_two_a: assert property (take && tbl_op
        |=> !tbl_low_valid ##1 tbl_low_valid) else $error("table timing");
    last_page_a: assert property (take && instr.op == op_tbl_last
        |=> &prog_addr[PC_WIDTH-1:8]) else $error("last page not used");
    vector_a: assert property (int_ack |=> prog_addr inside {`EXT_INT_VEC,
        `TMR0_VEC, `TMR1_VEC, `TMR2_VEC, `MULTI_VEC})
        else $error("interrupt not vectored");
    ack_dummy_a: assert property (int_ack |=> !instr_ready)
        else $error("no dummy after interrupt");
    pc_step_a: assert property (take && instr.op == op_alu
        |=> prog_addr == $past(prog_addr) + 1'b1) else $error("pc step");
    cover property (int_ack);
    cover property (take && instr.op == op_call);
    cover property (tbl_low_valid);
endmodule : seq_props

bind program_sequencer seq_props #(.PC_WIDTH(PC_WIDTH)) seq_props_i (
    .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .prog_addr(prog_addr), .result_valid(result_valid),
    .tbl_low_valid(tbl_low_valid), .int_ack(int_ack));

// ### verif/program_sequencer_tb.sv
// Purpose: directed tests of the program sequencer
// Assumes: tasks start on a rising edge
// Notes:   bus and instruction waits end only by the cycle ceiling
`timescale 1ns/100ps
`include "seq_cfg.svh"
module program_sequencer_tb
    import seq_pkg::*;
;
    logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        instr_valid, instr_ready, result_valid, tbl_low_valid;
    instr_type   instr;
    alu_out_type result;
    logic [14:0] prog_addr, pc_at;
    logic [15:0] prog_data;
    logic [7:0]  tbl_low_data;
    logic        int_ack, ext_int_pin, tmr0_ovf, tmr1_ovf, tmr2_ovf;
    logic        tbase_ovf, serial_done;
    int          n_fail, check_count, cycles, acks;
    alu_fn_type  fn_t[8] = '{alu_add, alu_sub, alu_and, alu_or, alu_xor,
                             alu_cpl, alu_rl, alu_rr};
    logic [7:0]  exp_t[8] = '{8'h2c, 8'hb4, 8'h30, 8'hfc, 8'hcc, 8'h0f,
                              8'h03, 8'hc0};

    program_sequencer #(.PC_WIDTH(15)) program_sequencer_i (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .result_valid(result_valid), .result(result),
        .tbl_low_valid(tbl_low_valid), .tbl_low_data(tbl_low_data),
        .ext_int_pin(ext_int_pin), .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf),
        .tmr2_ovf(tmr2_ovf), .tbase_ovf(tbase_ovf),
        .serial_done(serial_done), .int_ack(int_ack));
    prog_mem_model prog_mem_model_i (.prog_addr(prog_addr),
                                     .prog_data(prog_data));

    function automatic logic [15:0] word(input logic [14:0] a);
        return {a[7:0] ^ 8'h3c, a[14:7]};
    endfunction : word

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= wr ? 4'h1 : 4'hf;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                         input string msg);
        bus(1'b0, a, 32'h0);
        check(rd === e, msg);
    endtask : rdchk

    // leaves the caller at the accepting edge
    task automatic issue(input op_type op, input alu_fn_type fn,
                         input logic [7:0] a, input logic [7:0] b,
                         input logic [14:0] t);
        instr <= '{op, fn, a, b, t, 1'b0};
        instr_valid <= 1'b1;
        do @(posedge core_clk); while (instr_ready !== 1'b1);
        pc_at = prog_addr;
        instr_valid <= 1'b0;
    endtask : issue

    task automatic wait_addr(input logic [14:0] e, input string msg);
        for (int i = 0; i < 4 && prog_addr !== e; i++) @(posedge core_clk) #1;
        check(prog_addr === e, msg);
        @(posedge core_clk);
    endtask : wait_addr

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // cycle ceiling against a hung handshake
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            $display("unexpected at %0t: timeout", $time);
            results();
        end
    end

    initial begin
        {reset_n, avs_read, avs_write, instr_valid, ext_int_pin} = '0;
        {tmr0_ovf, tmr1_ovf, tmr2_ovf, tbase_ovf, serial_done} = '0;
        {avs_address, avs_byteenable, avs_writedata, instr} = '0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rdchk(`STACK_STAT_OFS, 32'h1, "stack not empty");
        rdchk(`PC_LOW_OFS, 32'h0, "pc low not at reset vector");
        rdchk(4'h7, 32'h0, "unmapped read");
        bus(1'b1, `TBL_PTR_OFS, 32'h06);
        rdchk(`TBL_PTR_OFS, 32'h06, "table pointer");
        bus(1'b1, `BANK_SEL_OFS, 32'h20);
        // ff + 01 wraps to zero with carry out
        issue(op_alu, alu_add, 8'hff, 8'h01, 15'h0);
        @(posedge core_clk);
        check(result.carry & result.zero, "add flags");
        for (int i = 0; i < 8; i++) begin
            issue(op_alu, fn_t[i], i < 6 ? 8'hf0 : 8'h81, 8'h3c, 15'h0);
            @(posedge core_clk);
            check(result.data === exp_t[i], "alu walk");
        end
        issue(op_alu, alu_xor, 8'hf0, 8'h3c, 15'h0);
        @(posedge core_clk);
        check(result.data === exp_t[4], "xor result");
        check(prog_addr === pc_at + 15'h1, "pc step");
        issue(op_skip, alu_pass, 8'h01, 8'h0, 15'h0);
        wait_addr(pc_at + 15'h2, "skip not taken");
        issue(op_jump, alu_pass, 8'h0, 8'h0, 15'h0123);
        wait_addr(15'h0123, "jump target");
        issue(op_tbl_cur, alu_pass, 8'h0, 8'h0, 15'h0);
        @(posedge core_clk) #1;
        check(tbl_low_data === 8'(word(15'h2106)), "current page");
        @(posedge core_clk);
        rdchk(`TBL_HIGH_OFS, {16'h0, word(15'h2106)} >> 8, "high");
        issue(op_tbl_last, alu_pass, 8'h0, 8'h0, 15'h0);
        @(posedge core_clk) #1;
        check(tbl_low_data === 8'(word(15'h7f06)), "last page");
        @(posedge core_clk);
        bus(1'b1, `PC_LOW_OFS, 32'h40);
        wait_addr(15'h0140, "pc low jump");
        issue(op_call, alu_pass, 8'h0, 8'h0, 15'h0200);
        rd = {17'h0, pc_at + 15'h1};
        wait_addr(15'h0200, "call target");
        issue(op_ret, alu_pass, 8'h0, 8'h0, 15'h0);
        wait_addr(rd[14:0], "return address");
        bus(1'b1, `INT_CTRL_OFS, 32'h08);
        for (int i = 0; i < 8; i++) begin
            issue(op_call, alu_pass, 8'h0, 8'h0, 15'h0300);
            @(posedge core_clk);
        end
        rdchk(`STACK_STAT_OFS, 32'h2, "stack not full");
        tmr0_ovf <= 1'b1;
        @(posedge core_clk);
        tmr0_ovf <= 1'b0;
        acks = 0;
        repeat (8) @(posedge core_clk) acks += int_ack;
        check(acks === 0, "acknowledge while full");
        rdchk(`INT_CTRL_OFS, 32'h0208, "flag not recorded");
        issue(op_ret, alu_pass, 8'h0, 8'h0, 15'h0);
        wait_addr(`TMR0_VEC, "timer vector");
        issue(op_call, alu_pass, 8'h0, 8'h0, 15'h0400);
        wait_addr(15'h0400, "call on full stack");
        results();
    end
endmodule : program_sequencer_tb
